// file: bit_skip_unit.sv
// Bit manipulation and conditional skip execution unit
//
// Overview of operation
// - Bit clear or set on IO register changes only that bit, no flags.
// - Bit clear or set on memory byte changes only that bit, no flags.
// - Carry exchange swaps IO bit with carry, only carry flag changes.
// - On an output pin, carry exchange drives the old carry to the port.
// - On an input pin, carry exchange loads the pin level into carry.
// - Direction bit 1 makes the pin an output, 0 an input.
// - Skip-if-equal compares working register with operand, skips on equal.
// - Skip-if-not-equal compares working register with operand, skips on differ.
// - Compares set all four flags as a subtraction, result discarded.
// - IO bit test skips on low or high bit, flags unchanged.
// - Memory bit test skips on low or high bit, flags unchanged.
// - Increment working register, write back, set flags, skip on zero.
// - Decrement working register, write back, set flags, skip on zero.
// - Increment memory byte in place, set flags, skip on zero.
// - Decrement memory byte in place, set flags, skip on zero.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module bit_skip_unit (
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  nrst,
	// Instruction stream from decode
	input  wire logic                  instr_valid,
	input  wire bit_skip_pkg::instr_t  instr,
	// Register port
	input  wire bit_skip_pkg::reg_req_t reg_req,
	output logic [7:0]                 reg_rdata,
	// Port A pins
	input  wire logic [7:0]            port_pin_in,
	output logic [7:0]                 port_out,
	output logic [7:0]                 port_oe,
	// Core state
	output logic [7:0]                 working_register,
	output logic [3:0]                 flags,
	output logic                       skip_pending
);

	// ****************************************************************
	// Adder shared by compare, increment and decrement
	// ****************************************************************
	function automatic bit_skip_pkg::alu_t alu_op(input logic [7:0] a,
		input logic [7:0] b, input logic sub);
		logic [8:0]          full;
		logic [4:0]          half;
		logic [7:0]          bb;
		bit_skip_pkg::alu_t  r;
		bb = sub ? ~b : b;
		full = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
		half = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
		r.res = full[7:0];
		r.flags[bit_skip_pkg::FLAG_Z] = (full[7:0] == 8'h00);
		// Borrow is the inverted carry on subtraction
		r.flags[bit_skip_pkg::FLAG_C] = full[8] ^ sub;
		r.flags[bit_skip_pkg::FLAG_AC] = half[4] ^ sub;
		r.flags[bit_skip_pkg::FLAG_OV] = (a[7] == bb[7]) & (full[7] != a[7]);
		return r;
	endfunction : alu_op

	// ****************************************************************
	// State and next state
	// ****************************************************************
	bit_skip_pkg::state_t s_q;
	bit_skip_pkg::state_t s_d;
	bit_skip_pkg::alu_t   alu_r;
	logic                 exec;
	logic [7:0]           io_rd;
	logic [7:0]           io_new;
	logic                 io_wr;
	logic [7:0]           mem_rd;
	logic [7:0]           mem_new;
	logic                 mem_wr;
	logic                 bit_v;
	logic                 c_old;

	// Output pins read back as the latch, input pins as the pin level
	assign io_rd = (instr.io_addr == bit_skip_pkg::IO_FLAGS) ?
		{4'h0, s_q.flags} :
		(instr.io_addr == bit_skip_pkg::IO_PORT) ?
		((s_q.dir & s_q.port_a_data) | (~s_q.dir & port_pin_in)) :
		(instr.io_addr == bit_skip_pkg::IO_DIR) ? s_q.dir : 8'h00;
	assign mem_rd = s_q.mem[instr.mem_addr];
	assign exec = instr_valid & ~s_q.skip;

	always_comb begin
		s_d = s_q;
		alu_r = '0;
		io_wr = 1'b0;
		mem_wr = 1'b0;
		c_old = s_q.flags[bit_skip_pkg::FLAG_C];
		// Base for IO writes is the latch, so input pins do not leak in
		io_new = (instr.io_addr == bit_skip_pkg::IO_PORT) ?
			s_q.port_a_data : io_rd;
		mem_new = mem_rd;
		bit_v = 1'b0;
		if (instr_valid && s_q.skip) begin
			s_d.skip = 1'b0;
		end
		if (exec) begin
			s_d.skip = 1'b0;
			case (instr.op)
			bit_skip_pkg::bit_clear_op_io,
			bit_skip_pkg::bit_force_high_op_io: begin
				io_new[instr.bit_sel] =
					(instr.op == bit_skip_pkg::bit_force_high_op_io);
				io_wr = 1'b1;
			end
			bit_skip_pkg::bit_clear_op_mem,
			bit_skip_pkg::bit_force_high_op_mem: begin
				mem_new[instr.bit_sel] =
					(instr.op == bit_skip_pkg::bit_force_high_op_mem);
				mem_wr = 1'b1;
			end
			bit_skip_pkg::op_swap_carry_io: begin
				// Input pins keep their latch; only carry picks up the pin
				if (instr.io_addr != bit_skip_pkg::IO_PORT ||
					s_q.dir[instr.bit_sel]) begin
					io_new[instr.bit_sel] = c_old;
					io_wr = 1'b1;
				end
			end
			bit_skip_pkg::op_skip_eq_imm, bit_skip_pkg::op_skip_ne_imm: begin
				alu_r = alu_op(s_q.wreg, instr.imm, 1'b1);
				s_d.flags = alu_r.flags;
				s_d.skip = (instr.op == bit_skip_pkg::op_skip_eq_imm) ==
					(s_q.wreg == instr.imm);
			end
			bit_skip_pkg::op_skip_eq_mem, bit_skip_pkg::op_skip_ne_mem: begin
				alu_r = alu_op(s_q.wreg, mem_rd, 1'b1);
				s_d.flags = alu_r.flags;
				s_d.skip = (instr.op == bit_skip_pkg::op_skip_eq_mem) ==
					(s_q.wreg == mem_rd);
			end
			bit_skip_pkg::skip_if_bit_low_op_io,
			bit_skip_pkg::skip_if_bit_high_op_io: begin
				bit_v = io_rd[instr.bit_sel];
				s_d.skip = (instr.op == bit_skip_pkg::skip_if_bit_high_op_io)
					== bit_v;
			end
			bit_skip_pkg::skip_if_bit_low_op_mem,
			bit_skip_pkg::skip_if_bit_high_op_mem: begin
				bit_v = mem_rd[instr.bit_sel];
				s_d.skip = (instr.op == bit_skip_pkg::skip_if_bit_high_op_mem)
					== bit_v;
			end
			bit_skip_pkg::op_inc_skip_w, bit_skip_pkg::op_dec_skip_w: begin
				alu_r = alu_op(s_q.wreg, 8'h01,
					instr.op == bit_skip_pkg::op_dec_skip_w);
				s_d.wreg = alu_r.res;
				s_d.flags = alu_r.flags;
				s_d.skip = (alu_r.res == 8'h00);
			end
			bit_skip_pkg::op_inc_skip_mem, bit_skip_pkg::op_dec_skip_mem: begin
				alu_r = alu_op(mem_rd, 8'h01,
					instr.op == bit_skip_pkg::op_dec_skip_mem);
				mem_new = alu_r.res;
				mem_wr = 1'b1;
				s_d.flags = alu_r.flags;
				s_d.skip = (alu_r.res == 8'h00);
			end
			default: begin
			end
			endcase
			if (io_wr) begin
				case (instr.io_addr)
				bit_skip_pkg::IO_FLAGS: s_d.flags = io_new[3:0];
				bit_skip_pkg::IO_PORT:  s_d.port_a_data = io_new;
				bit_skip_pkg::IO_DIR:   s_d.dir = io_new;
				default: begin
				end
				endcase
			end
			if (instr.op == bit_skip_pkg::op_swap_carry_io) begin
				s_d.flags[bit_skip_pkg::FLAG_C] = io_rd[instr.bit_sel];
			end
			if (mem_wr) begin
				s_d.mem[instr.mem_addr] = mem_new;
			end
		end
		// Software writes land after the instruction and win on a clash
		if (reg_req.wr) begin
			if (reg_req.addr[4]) begin
				s_d.mem[reg_req.addr[3:0]] = reg_req.wdata;
			end else begin
				case (reg_req.addr)
				bit_skip_pkg::REG_WREG:  s_d.wreg = reg_req.wdata;
				bit_skip_pkg::REG_FLAGS: s_d.flags = reg_req.wdata[3:0];
				bit_skip_pkg::REG_PORT:  s_d.port_a_data = reg_req.wdata;
				bit_skip_pkg::REG_DIR:   s_d.dir = reg_req.wdata;
				default: begin
				end
				endcase
			end
		end
		s_d.rdata = 8'h00;
		if (reg_req.rd) begin
			if (reg_req.addr[4]) begin
				s_d.rdata = s_q.mem[reg_req.addr[3:0]];
			end else begin
				case (reg_req.addr)
				bit_skip_pkg::REG_WREG:   s_d.rdata = s_q.wreg;
				bit_skip_pkg::REG_FLAGS:  s_d.rdata = {4'h0, s_q.flags};
				bit_skip_pkg::REG_PORT:   s_d.rdata = s_q.port_a_data;
				bit_skip_pkg::REG_DIR:    s_d.rdata = s_q.dir;
				bit_skip_pkg::REG_PINS:   s_d.rdata = port_pin_in;
				bit_skip_pkg::REG_STATUS: s_d.rdata = {7'h00, s_q.skip};
				default:                  s_d.rdata = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.wreg <= bit_skip_pkg::WREG_RST;
			s_q.flags <= bit_skip_pkg::FLAGS_RST;
			s_q.port_a_data <= bit_skip_pkg::PORT_RST;
			s_q.dir <= bit_skip_pkg::DIR_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign port_out = s_q.port_a_data;
	assign port_oe = s_q.dir;
	assign working_register = s_q.wreg;
	assign flags = s_q.flags;
	assign skip_pending = s_q.skip;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	logic go;
	assign go = exec & ~reg_req.wr;

	a_io_clear_bit: assert property (go && instr.io_addr == 2'h1 &&
		instr.op == bit_skip_pkg::bit_clear_op_io |=>
		!port_out[$past(instr.bit_sel)] && flags == $past(flags))
		else $error("io bit clear wrong");
	a_mem_set_bit: assert property (go &&
		instr.op == bit_skip_pkg::bit_force_high_op_mem |=>
		s_q.mem[$past(instr.mem_addr)][$past(instr.bit_sel)] &&
		flags == $past(flags))
		else $error("memory bit set wrong");
	a_swap_flags_kept: assert property (go && instr.io_addr == 2'h1 &&
		instr.op == bit_skip_pkg::op_swap_carry_io |=>
		{flags[3:2], flags[0]} == $past({flags[3:2], flags[0]}))
		else $error("swap touched other flags");
	a_swap_drive_out: assert property (go && instr.io_addr == 2'h1 &&
		instr.op == bit_skip_pkg::op_swap_carry_io &&
		port_oe[instr.bit_sel] |=>
		port_out[$past(instr.bit_sel)] == $past(flags[1]))
		else $error("carry not driven to port");
	a_swap_load_pin: assert property (go && instr.io_addr == 2'h1 &&
		instr.op == bit_skip_pkg::op_swap_carry_io &&
		!port_oe[instr.bit_sel] |=>
		flags[1] == $past(port_pin_in[instr.bit_sel]))
		else $error("pin not loaded to carry");
	a_dir_write: assert property (reg_req.wr && reg_req.addr == 5'h03
		|=> port_oe == $past(reg_req.wdata))
		else $error("direction write lost");
	a_eq_skip: assert property (go &&
		instr.op == bit_skip_pkg::op_skip_eq_imm |=>
		skip_pending == ($past(working_register) == $past(instr.imm)))
		else $error("equal skip wrong");
	a_ne_skip: assert property (go &&
		instr.op == bit_skip_pkg::op_skip_ne_mem |=>
		skip_pending == ($past(working_register) != $past(mem_rd)))
		else $error("not-equal skip wrong");
	a_cmp_no_write: assert property (go &&
		instr.op == bit_skip_pkg::op_skip_eq_imm |=>
		working_register == $past(working_register) &&
		flags[0] == skip_pending &&
		flags[1] == ($past(working_register) < $past(instr.imm)))
		else $error("compare flags wrong");
	a_io_bit_test: assert property (go && instr.io_addr == 2'h2 &&
		instr.op == bit_skip_pkg::skip_if_bit_low_op_io |=>
		skip_pending == !$past(port_oe[instr.bit_sel]) &&
		flags == $past(flags))
		else $error("io bit test wrong");
	a_mem_bit_test: assert property (go &&
		instr.op == bit_skip_pkg::skip_if_bit_high_op_mem |=>
		skip_pending == $past(mem_rd[instr.bit_sel]) &&
		flags == $past(flags))
		else $error("memory bit test wrong");
	a_inc_w_skip: assert property (go &&
		instr.op == bit_skip_pkg::op_inc_skip_w |=>
		working_register == 8'($past(working_register) + 8'h01) &&
		skip_pending == (working_register == 8'h00) &&
		flags[0] == skip_pending)
		else $error("increment skip wrong");
	a_dec_w_skip: assert property (go &&
		instr.op == bit_skip_pkg::op_dec_skip_w |=>
		working_register == 8'($past(working_register) - 8'h01) &&
		skip_pending == (working_register == 8'h00) &&
		flags[1] == ($past(working_register) == 8'h00))
		else $error("decrement skip wrong");
	a_inc_mem_skip: assert property (go &&
		instr.op == bit_skip_pkg::op_inc_skip_mem |=>
		s_q.mem[$past(instr.mem_addr)] == 8'($past(mem_rd) + 8'h01) &&
		skip_pending == (s_q.mem[$past(instr.mem_addr)] == 8'h00))
		else $error("memory increment wrong");
	a_dec_mem_skip: assert property (go &&
		instr.op == bit_skip_pkg::op_dec_skip_mem |=>
		s_q.mem[$past(instr.mem_addr)] == 8'($past(mem_rd) - 8'h01) &&
		skip_pending == ($past(mem_rd) == 8'h01))
		else $error("memory decrement wrong");
	a_skip_is_nop: assert property (instr_valid && skip_pending &&
		!reg_req.wr |=> !skip_pending &&
		$stable(working_register) && $stable(flags) &&
		$stable(port_out) && $stable(port_oe) && $stable(s_q.mem))
		else $error("skipped instruction had effect");

	c_swap_output: cover property (go &&
		instr.op == bit_skip_pkg::op_swap_carry_io && port_oe[0]);
	c_dec_to_zero: cover property (go &&
		instr.op == bit_skip_pkg::op_dec_skip_w ##1 skip_pending);
	c_skip_consumed: cover property (skip_pending && instr_valid ##1
		!skip_pending);

endmodule : bit_skip_unit
`default_nettype wire

// file: bit_skip_pkg.sv
// Constants and types for the bit and skip instruction unit
`default_nettype none
package bit_skip_pkg;

	// ****************************************************************
	// Widths and flag positions
	// ****************************************************************
	localparam int unsigned DATA_W    = 8;
	localparam int unsigned MEM_DEPTH = 16;
	localparam int unsigned FLAG_Z    = 0;
	localparam int unsigned FLAG_C    = 1;
	localparam int unsigned FLAG_AC   = 2;
	localparam int unsigned FLAG_OV   = 3;

	// ****************************************************************
	// IO space seen by instructions
	// ****************************************************************
	localparam logic [1:0] IO_FLAGS = 2'h0;
	localparam logic [1:0] IO_PORT  = 2'h1;
	localparam logic [1:0] IO_DIR   = 2'h2;

	// ****************************************************************
	// Register port offsets
	// ****************************************************************
	localparam logic [4:0] REG_WREG   = 5'h00;
	localparam logic [4:0] REG_FLAGS  = 5'h01;
	localparam logic [4:0] REG_PORT   = 5'h02;
	localparam logic [4:0] REG_DIR    = 5'h03;
	localparam logic [4:0] REG_PINS   = 5'h04;
	localparam logic [4:0] REG_STATUS = 5'h05;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] WREG_RST  = 8'h00;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	localparam logic [7:0] PORT_RST  = 8'h00;
	localparam logic [7:0] DIR_RST   = 8'h00;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [4:0] {
		op_nop                    = 5'h00,
		bit_clear_op_io           = 5'h01,
		bit_force_high_op_io      = 5'h02,
		bit_clear_op_mem          = 5'h03,
		bit_force_high_op_mem     = 5'h04,
		op_swap_carry_io          = 5'h05,
		op_skip_eq_imm            = 5'h06,
		op_skip_eq_mem            = 5'h07,
		op_skip_ne_imm            = 5'h08,
		op_skip_ne_mem            = 5'h09,
		skip_if_bit_low_op_io     = 5'h0a,
		skip_if_bit_high_op_io    = 5'h0b,
		skip_if_bit_low_op_mem    = 5'h0c,
		skip_if_bit_high_op_mem   = 5'h0d,
		op_inc_skip_w             = 5'h0e,
		op_dec_skip_w             = 5'h0f,
		op_inc_skip_mem           = 5'h10,
		op_dec_skip_mem           = 5'h11
	} op_t;

	typedef struct packed {
		op_t        op;
		logic [2:0] bit_sel;
		logic [1:0] io_addr;
		logic [3:0] mem_addr;
		logic [7:0] imm;
	} instr_t;

	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] res;
		logic [3:0] flags;
	} alu_t;

	typedef struct packed {
		logic [7:0]        wreg;
		logic [3:0]        flags;
		logic [7:0]        port_a_data;
		logic [7:0]        dir;
		logic [15:0][7:0]  mem;
		logic              skip;
		logic [7:0]        rdata;
	} state_t;

endpackage : bit_skip_pkg
`default_nettype wire

// file: bit_skip_unit_tb.sv
// Self-checking testbench for the bit and skip instruction unit
`timescale 1ns/10ps
`default_nettype none
module bit_skip_unit_tb;

	// ****************************************************************
	// Signals
	// ****************************************************************
	logic                   mclk;
	logic                   nrst;
	logic                   instr_valid;
	bit_skip_pkg::instr_t   instr;
	bit_skip_pkg::reg_req_t reg_req;
	logic [7:0]             reg_rdata;
	logic [7:0]             port_pin_in;
	logic [7:0]             port_out;
	logic [7:0]             port_oe;
	logic [7:0]             working_register;
	logic [3:0]             flags;
	logic                   skip_pending;
	logic [7:0]             rv;
	int                     fail_count;
	int                     n_tests;

	bit_skip_unit bit_skip_unit_inst (
		.mclk            (mclk),
		.nrst            (nrst),
		.instr_valid     (instr_valid),
		.instr           (instr),
		.reg_req         (reg_req),
		.reg_rdata       (reg_rdata),
		.port_pin_in     (port_pin_in),
		.port_out        (port_out),
		.port_oe         (port_oe),
		.working_register(working_register),
		.flags           (flags),
		.skip_pending    (skip_pending)
	);

	// ****************************************************************
	// Expected flags, order OV AC C Z from bit 3 down
	// ****************************************************************
	function automatic logic [3:0] sub_f(input logic [7:0] a,
		input logic [7:0] b);
		logic [7:0] r;
		r = a - b;
		sub_f = {(a[7] != b[7]) && (r[7] != a[7]), a[3:0] < b[3:0], a < b,
			r == 8'h00};
	endfunction : sub_f

	function automatic logic [3:0] add_f(input logic [7:0] a);
		add_f = {a == 8'h7f, a[3:0] == 4'hf, a == 8'hff, a == 8'hff};
	endfunction : add_f

	// ****************************************************************
	// Checks and closing
	// ****************************************************************
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
		input string msg);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t %s got %b exp %b", $time, msg, got, exp);
		end
	endtask : chk1

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test

	// ****************************************************************
	// Access tasks
	// ****************************************************************
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
		reg_req <= '{a, d, 1'b0, 1'b0};
		#1;
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk);
		reg_req <= '{a, 8'h00, 1'b0, 1'b0};
		#1;
		d = reg_rdata;
	endtask : rd

	task automatic exec(input bit_skip_pkg::op_t op, input logic [2:0] b,
		input logic [1:0] io, input logic [3:0] m, input logic [7:0] imm);
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr       <= '{op, b, io, m, imm};
		@(posedge mclk);
		instr_valid <= 1'b0;
		#1;
	endtask : exec

	// ****************************************************************
	// Compare-and-skip case, operand in byte 4 and in the immediate
	// ****************************************************************
	task automatic cmp(input bit_skip_pkg::op_t op, input logic [7:0] a,
		input logic [7:0] b);
		logic s;
		s = ((op == bit_skip_pkg::op_skip_eq_imm) ||
			(op == bit_skip_pkg::op_skip_eq_mem)) ? (a == b) : (a != b);
		wr(bit_skip_pkg::REG_WREG, a);
		wr(5'h14, b);
		exec(op, 3'h0, 2'h0, 4'h4, b);
		chk8(working_register, a, "cmp wreg");
		chk8({4'h0, flags}, {4'h0, sub_f(a, b)}, "cmp flags");
		chk1(skip_pending, s, "cmp skip");
		if (s) begin
			exec(bit_skip_pkg::op_inc_skip_w, 3'h0, 2'h0, 4'h0, 8'h00);
			chk8(working_register, a, "skipped inc");
			chk1(skip_pending, 1'b0, "skip consumed");
		end
	endtask : cmp

	// ****************************************************************
	// Increment/decrement-skip case on wreg or byte 5
	// ****************************************************************
	task automatic ids(input bit_skip_pkg::op_t op, input logic [7:0] v);
		logic       w;
		logic       inc;
		logic [7:0] r;
		logic [3:0] f;
		logic       sk;
		w = (op == bit_skip_pkg::op_inc_skip_w) ||
			(op == bit_skip_pkg::op_dec_skip_w);
		inc = (op == bit_skip_pkg::op_inc_skip_w) ||
			(op == bit_skip_pkg::op_inc_skip_mem);
		r = inc ? v + 8'h01 : v - 8'h01;
		f = inc ? add_f(v) : sub_f(v, 8'h01);
		wr(w ? bit_skip_pkg::REG_WREG : 5'h15, v);
		sk = (r == 8'h00);
		repeat (2) begin
			exec(op, 3'h0, 2'h0, 4'h5, 8'h00);
			if (w) rv = working_register;
			else rd(5'h15, rv);
			chk8(rv, r, "inc/dec value");
			chk8({4'h0, flags}, {4'h0, f}, "inc/dec flags");
			chk1(skip_pending, sk, "inc/dec skip");
			// Second pass is the skipped copy: nothing moves, skip clears
			if (!sk) break;
			sk = 1'b0;
		end
	endtask : ids

	// ****************************************************************
	// Clock, watchdog and main sequence
	// ****************************************************************
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial begin
		#1000000;
		fail_count++;
		end_of_test();
	end

	initial begin
		nrst        = 1'b0;
		instr_valid = 1'b0;
		instr       = '0;
		reg_req     = '0;
		port_pin_in = 8'h00;
		fail_count  = 0;
		n_tests     = 0;
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		#1;
		chk8(port_out, bit_skip_pkg::PORT_RST, "port reset");
		chk8(port_oe, bit_skip_pkg::DIR_RST, "dir reset");
		chk8(working_register, bit_skip_pkg::WREG_RST, "wreg reset");
		chk8({4'h0, flags}, {4'h0, bit_skip_pkg::FLAGS_RST}, "flag reset");
		chk1(skip_pending, 1'b0, "skip reset");
		for (int i = 0; i < 9; i++) begin
			rd(5'(i), rv);
			chk8(rv, 8'h00, "reg reset");
		end
		wr(bit_skip_pkg::REG_DIR, 8'h0f);
		chk8(port_oe, 8'h0f, "dir write");
		wr(bit_skip_pkg::REG_FLAGS, 8'h0a);
		exec(bit_skip_pkg::bit_force_high_op_io, 3'h5, bit_skip_pkg::IO_PORT,
			4'h0, 8'h00);
		chk8(port_out, 8'h20, "io set");
		exec(bit_skip_pkg::bit_force_high_op_io, 3'h7, bit_skip_pkg::IO_DIR,
			4'h0, 8'h00);
		chk8(port_oe, 8'h8f, "dir bit set");
		exec(bit_skip_pkg::bit_clear_op_io, 3'h5, bit_skip_pkg::IO_PORT,
			4'h0, 8'h00);
		chk8(port_out, 8'h00, "io clear");
		chk8({4'h0, flags}, 8'h0a, "io flags");
		wr(5'h13, 8'h55);
		exec(bit_skip_pkg::bit_force_high_op_mem, 3'h1, 2'h0, 4'h3, 8'h00);
		exec(bit_skip_pkg::bit_clear_op_mem, 3'h0, 2'h0, 4'h3, 8'h00);
		rd(5'h13, rv);
		chk8(rv, 8'h56, "mem bits");
		chk8({4'h0, flags}, 8'h0a, "mem flags");
		wr(bit_skip_pkg::REG_FLAGS, 8'h02);
		exec(bit_skip_pkg::op_swap_carry_io, 3'h0, bit_skip_pkg::IO_PORT,
			4'h0, 8'h00);
		chk8(port_out, 8'h01, "swap out pin");
		chk8({4'h0, flags}, 8'h00, "swap out carry");
		// Bit 4 is an input: pin goes to carry, latch stays
		@(posedge mclk);
		port_pin_in <= 8'h10;
		rd(bit_skip_pkg::REG_PINS, rv);
		chk8(rv, 8'h10, "pin read");
		exec(bit_skip_pkg::op_swap_carry_io, 3'h4, bit_skip_pkg::IO_PORT,
			4'h0, 8'h00);
		chk8({4'h0, flags}, 8'h02, "swap in carry");
		chk8(port_out, 8'h01, "swap in latch");
		wr(bit_skip_pkg::REG_FLAGS, 8'h05);
		exec(bit_skip_pkg::skip_if_bit_low_op_io, 3'h4, bit_skip_pkg::IO_PORT,
			4'h0, 8'h00);
		chk1(skip_pending, 1'b0, "io low test");
		exec(bit_skip_pkg::skip_if_bit_high_op_io, 3'h4,
			bit_skip_pkg::IO_PORT, 4'h0, 8'h00);
		chk1(skip_pending, 1'b1, "io high test");
		rd(bit_skip_pkg::REG_STATUS, rv);
		chk8(rv, 8'h01, "status skip");
		exec(bit_skip_pkg::bit_force_high_op_io, 3'h6, bit_skip_pkg::IO_PORT,
			4'h0, 8'h00);
		chk8(port_out, 8'h01, "skipped io set");
		chk1(skip_pending, 1'b0, "skip gone");
		exec(bit_skip_pkg::skip_if_bit_low_op_io, 3'h4, bit_skip_pkg::IO_DIR,
			4'h0, 8'h00);
		chk1(skip_pending, 1'b1, "dir low test");
		exec(bit_skip_pkg::bit_clear_op_io, 3'h0, bit_skip_pkg::IO_PORT,
			4'h0, 8'h00);
		chk8(port_out, 8'h01, "skipped io clear");
		chk1(skip_pending, 1'b0, "skip gone again");
		wr(5'h12, 8'h80);
		exec(bit_skip_pkg::skip_if_bit_low_op_mem, 3'h7, 2'h0, 4'h2, 8'h00);
		chk1(skip_pending, 1'b0, "mem low test");
		exec(bit_skip_pkg::skip_if_bit_high_op_mem, 3'h7, 2'h0, 4'h2, 8'h00);
		chk1(skip_pending, 1'b1, "mem high test");
		exec(bit_skip_pkg::op_inc_skip_mem, 3'h0, 2'h0, 4'h2, 8'h00);
		rd(5'h12, rv);
		chk8(rv, 8'h80, "skipped mem inc");
		chk8({4'h0, flags}, 8'h05, "test flags");
		cmp(bit_skip_pkg::op_skip_eq_imm, 8'h55, 8'h55);
		cmp(bit_skip_pkg::op_skip_eq_imm, 8'h12, 8'h34);
		cmp(bit_skip_pkg::op_skip_eq_mem, 8'h3c, 8'h3c);
		cmp(bit_skip_pkg::op_skip_ne_imm, 8'h80, 8'h01);
		cmp(bit_skip_pkg::op_skip_ne_mem, 8'h10, 8'h01);
		cmp(bit_skip_pkg::op_skip_ne_mem, 8'ha5, 8'ha5);
		ids(bit_skip_pkg::op_inc_skip_w, 8'hff);
		ids(bit_skip_pkg::op_inc_skip_w, 8'h7f);
		ids(bit_skip_pkg::op_dec_skip_w, 8'h01);
		ids(bit_skip_pkg::op_dec_skip_w, 8'h00);
		ids(bit_skip_pkg::op_inc_skip_mem, 8'hff);
		ids(bit_skip_pkg::op_inc_skip_mem, 8'h0f);
		ids(bit_skip_pkg::op_dec_skip_mem, 8'h01);
		ids(bit_skip_pkg::op_dec_skip_mem, 8'h80);
		end_of_test();
	end

endmodule : bit_skip_unit_tb
`default_nettype wire
